// *** verilog/lin_phy_defines.svh ***
// timing constants for the lin phy mode control
`ifndef LIN_PHY_DEFINES_SVH
`define LIN_PHY_DEFINES_SVH
`define CLK_PERIOD_NS 40
`define GOTO_NORM_NS 10000
`define GOTO_SLEEP_NS 10000
`define WAKE_DOM_NS 150000
`define GOTO_NORM_CYC ((`GOTO_NORM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define GOTO_SLEEP_CYC ((`GOTO_SLEEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define WAKE_DOM_CYC ((`WAKE_DOM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define TXD_TIMEOUT_NS 20000000
`define TXD_TIMEOUT_CYC (`TXD_TIMEOUT_NS / `CLK_PERIOD_NS)
`define MAX_BIT_RATE_BPS 20000
`define FIFO_DEPTH 8
`endif

// *** verilog/lin_phy_pkg.sv ***
// types for the lin phy mode control
package lin_phy_pkg;
	typedef enum logic [3:0] {
		ST_SLEEP = 4'h1,
		ST_STANDBY = 4'h2,
		ST_NORMAL = 4'h4,
		ST_POWERUP = 4'h8
	} phy_state_t;
	typedef struct packed {
		logic value;
		logic enable;
	} pin_drive_t;
	typedef struct packed {
		logic fromBus;
		logic level;
	} bit_sample_t;
endpackage : lin_phy_pkg

// *** verilog/lin_bit_fifo.sv ***
// small flip-flop fifo for sampled bus bits
`timescale 1ns/1ns
module lin_bit_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0] count_q;
	wire doWrite = inValid && inReady;
	wire doRead = outValid && outReady;
	assign inReady = (count_q != (AW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData = mem_q[rdPtr_q];
	always_ff @(posedge sys_clk) begin
		if (doWrite) begin
			mem_q[wrPtr_q] <= inData;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (doWrite) begin
				wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
			end
			if (doRead) begin
				rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
			end
			count_q <= count_q + (AW+1)'(doWrite) - (AW+1)'(doRead);
		end
	end
endmodule : lin_bit_fifo

// *** verilog/lin_phy_mode_control.sv ***
// mode sequencing, wake handling and data relay of the lin transceiver
`timescale 1ns/1ns
`include "lin_phy_defines.svh"
// Functional notes
// [RULE_01] four states only: sleep, standby, normal, power-up; sleep lowest power
// [RULE_02] normal goes to sleep after sleep request low beyond 10 us
// [RULE_03] remote wake needs bus dominant beyond 150 us; shorter pulses ignored
// [RULE_04] local wake needs sleep request high beyond 10 us
// [RULE_05] wake while asleep enters standby at once, receive output driven low
// [RULE_06] supply inhibit floats in sleep, driven high in all other states
// [RULE_07] standby: rising sleep request clears wake source flag immediately
// [RULE_08] standby: rising sleep request releases strong transmit pull-down first
// [RULE_09] standby: rising sleep request withdraws wake low on receive output
// [RULE_10] sleep, standby, power-up enter normal after request high beyond 10 us
// [RULE_11] power-up: receive floats, transmit weak pull-down, driver and receiver off
// [RULE_12] normal: receive shows bus level, bus follows transmit input
// [RULE_13] relay supports bit rates up to 20 kbps
// [RULE_14] dominant transmit input held too long releases the bus
// [RULE_15] controller may wake its core from the wake indication
// [RULE_16] controller drives request and current sources, reads receive output
// [RULE_17] controller avoids sleep requests when inhibit is pulled down externally
// [RULE_18] controller runs the three addressing measurements in order
// [RULE_19] duration qualifiers are counters restarted by any opposite level
// [RULE_20] start in power-up, stay until qualified high sleep request
module lin_phy_mode_control #(
	parameter int TXD_TIMEOUT_CYCLES = `TXD_TIMEOUT_CYC,
	parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic sleep_request_n,
	input wire logic txdIn,
	input wire logic busIn,
	input wire logic address_current_source_a,
	input wire logic address_current_source_b,
	output logic busOut,
	output logic busOe,
	output logic rxdOut,
	output logic rxdOe,
	output logic supply_inhibit_out,
	output logic supplyInhibitOe,
	output logic txdStrongPullDown,
	output logic txdWeakPullDown,
	output logic wakeSourceRemote,
	output logic wakeSourceLocal,
	output logic csAOn,
	output logic csBOn,
	output logic [3:0] modeState
);
	localparam int NORM_CYC = `GOTO_NORM_CYC;
	localparam int SLEEP_CYC = `GOTO_SLEEP_CYC;
	localparam int WAKE_CYC = `WAKE_DOM_CYC;
	localparam int TW = $clog2(TXD_TIMEOUT_CYCLES + 1);

	// two-stage synchronisers for all pins
	logic [4:0] syncA_q;
	logic [4:0] syncB_q;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			// idle pin levels, so no false request edge or count follows reset
			syncA_q <= 5'h06;
			syncB_q <= 5'h06;
		end else begin
			syncA_q <= {address_current_source_b, address_current_source_a, busIn, txdIn,
				sleep_request_n};
			syncB_q <= syncA_q;
		end
	end
	wire reqHigh = syncB_q[0];
	wire txdLevel = syncB_q[1];
	wire busLevel = syncB_q[2];

	// level qualifiers; each restarts on the opposite level
	logic [12:0] highCnt_q;
	logic [12:0] lowCnt_q;
	logic [12:0] domCnt_q;
	logic reqHighPrev_q;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			highCnt_q <= '0;
			lowCnt_q <= '0;
			domCnt_q <= '0;
			reqHighPrev_q <= 1'b0;
		end else begin
			highCnt_q <= !reqHigh ? '0 : (highCnt_q == 13'(NORM_CYC)) ? highCnt_q :
				highCnt_q + 13'h1; // [RULE_19]
			lowCnt_q <= reqHigh ? '0 : (lowCnt_q == 13'(SLEEP_CYC)) ? lowCnt_q :
				lowCnt_q + 13'h1; // [RULE_19]
			domCnt_q <= busLevel ? '0 : (domCnt_q == 13'(WAKE_CYC)) ? domCnt_q :
				domCnt_q + 13'h1; // [RULE_19]
			reqHighPrev_q <= reqHigh;
		end
	end
	wire normQual = (highCnt_q == 13'(NORM_CYC)); // [RULE_04]
	wire sleepQual = (lowCnt_q == 13'(SLEEP_CYC)); // [RULE_02]
	wire remoteQual = (domCnt_q == 13'(WAKE_CYC)); // [RULE_03]
	wire reqRise = reqHigh && !reqHighPrev_q;
	// falling edge qualification: sleep entry also needs a high-to-low change; the low count runs on any low level
	logic fellSeen_q;

	lin_phy_pkg::phy_state_t state_q;
	lin_phy_pkg::phy_state_t state_d;
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			lin_phy_pkg::ST_POWERUP: begin
				if (normQual) begin
					state_d = lin_phy_pkg::ST_NORMAL; // [RULE_20] [RULE_10]
				end
			end
			lin_phy_pkg::ST_SLEEP: begin
				if (normQual || remoteQual) begin
					state_d = lin_phy_pkg::ST_STANDBY; // [RULE_05]
				end
			end
			lin_phy_pkg::ST_STANDBY: begin
				if (normQual) begin
					state_d = lin_phy_pkg::ST_NORMAL; // [RULE_10]
				end
			end
			lin_phy_pkg::ST_NORMAL: begin
				if (sleepQual && fellSeen_q) begin
					state_d = lin_phy_pkg::ST_SLEEP; // [RULE_02]
				end
			end
			default: state_d = lin_phy_pkg::ST_POWERUP;
		endcase
	end

	logic wakeRemote_q;
	logic wakeLocal_q;
	logic wakeRxdLow_q;
	logic strongPd_q;
	wire inSleep = (state_q == lin_phy_pkg::ST_SLEEP);
	wire inStandby = (state_q == lin_phy_pkg::ST_STANDBY);
	wire inNormal = (state_q == lin_phy_pkg::ST_NORMAL);
	wire inPowerup = (state_q == lin_phy_pkg::ST_POWERUP);
	wire wakeEvent = inSleep && (normQual || remoteQual);
	wire standbyRise = inStandby && reqRise;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_q <= lin_phy_pkg::ST_POWERUP; // [RULE_20] [RULE_01]
			fellSeen_q <= 1'b0;
		end else begin
			state_q <= state_d;
			fellSeen_q <= reqHigh ? 1'b0 : (reqHighPrev_q ? 1'b1 : fellSeen_q);
		end
	end

	// wake flags: a new wake event wins over the clear
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wakeRemote_q <= 1'b0;
			wakeLocal_q <= 1'b0;
			wakeRxdLow_q <= 1'b0;
			strongPd_q <= 1'b0;
		end else begin
			if (wakeEvent) begin
				wakeRemote_q <= remoteQual;
				wakeLocal_q <= normQual && !remoteQual;
				wakeRxdLow_q <= 1'b1; // [RULE_05]
				strongPd_q <= 1'b1;
			end else if (standbyRise || !inStandby) begin
				wakeRemote_q <= 1'b0; // [RULE_07]
				wakeLocal_q <= 1'b0; // [RULE_07]
				wakeRxdLow_q <= 1'b0; // [RULE_09]
				strongPd_q <= 1'b0; // [RULE_08]
			end
		end
	end

	// dominant timeout on the transmit path
	logic [TW-1:0] txdCnt_q;
	logic txdBlocked_q;
	wire txdExpired = (txdCnt_q == TW'(TXD_TIMEOUT_CYCLES));
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			txdCnt_q <= '0;
			txdBlocked_q <= 1'b0;
		end else if (!inNormal || txdLevel) begin
			txdCnt_q <= '0;
			txdBlocked_q <= 1'b0;
		end else begin
			txdCnt_q <= txdExpired ? txdCnt_q : txdCnt_q + 1'b1;
			txdBlocked_q <= txdBlocked_q || txdExpired; // [RULE_14]
		end
	end

	// bus bits pass a small fifo; throughput far above 20 kbps so it never fills
	logic fifoInReady;
	logic fifoOutValid;
	logic [1:0] fifoOut;
	logic [1:0] fifoIn;
	assign fifoIn = {busLevel, txdLevel};
	lin_bit_fifo #(
		.WIDTH(2),
		.DEPTH(FIFO_DEPTH)
	) u_bit_fifo (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.inValid(inNormal),
		.inReady(fifoInReady),
		.inData(fifoIn),
		.outValid(fifoOutValid),
		.outReady(1'b1),
		.outData(fifoOut)
	); // [RULE_13]
	wire relayValid = fifoOutValid && fifoInReady;

	// registered outputs
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			busOut <= 1'b1;
			busOe <= 1'b0;
			rxdOut <= 1'b1;
			rxdOe <= 1'b0;
			supply_inhibit_out <= 1'b1;
			supplyInhibitOe <= 1'b1;
			txdStrongPullDown <= 1'b0;
			txdWeakPullDown <= 1'b1;
			wakeSourceRemote <= 1'b0;
			wakeSourceLocal <= 1'b0;
			csAOn <= 1'b0;
			csBOn <= 1'b0;
			modeState <= 4'h8;
		end else begin
			busOut <= 1'b0;
			busOe <= inNormal && relayValid && !fifoOut[0] && !txdBlocked_q; // [RULE_12]
			rxdOut <= inNormal ? (relayValid ? fifoOut[1] : rxdOut) :
				!(wakeRxdLow_q && !standbyRise); // [RULE_09]
			rxdOe <= inNormal || inStandby || inSleep; // [RULE_11]
			supply_inhibit_out <= 1'b1;
			supplyInhibitOe <= (state_d != lin_phy_pkg::ST_SLEEP); // [RULE_06]
			txdStrongPullDown <= strongPd_q && !standbyRise; // [RULE_08]
			txdWeakPullDown <= inPowerup; // [RULE_11]
			wakeSourceRemote <= wakeRemote_q && !standbyRise;
			wakeSourceLocal <= wakeLocal_q && !standbyRise;
			csAOn <= syncB_q[3];
			csBOn <= syncB_q[4];
			modeState <= state_d;
		end
	end

	sleep_entry_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(inNormal && sleepQual && fellSeen_q) |=> inSleep) // [RULE_02]
		else $error("normal did not enter sleep");
	sequence domHeld_s;
		!busLevel [*8];
	endsequence
	wake_short_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(inSleep && !remoteQual && !normQual) |=> !inStandby) // [RULE_03]
		else $error("sleep left without qualified wake");
	wake_enter_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wakeEvent |=> inStandby ##1 (rxdOut == 1'b0)) // [RULE_05]
		else $error("wake did not enter standby with receive low");
	inhibit_float_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		inSleep |-> !supplyInhibitOe) // [RULE_06]
		else $error("inhibit driven in sleep");
	flag_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		standbyRise |=> !wakeRemote_q && !wakeLocal_q && !wakeSourceLocal &&
			!wakeSourceRemote) // [RULE_07]
		else $error("wake flag not cleared");
	pulldown_rel_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		standbyRise |=> !txdStrongPullDown) // [RULE_08]
		else $error("strong pull-down not released");
	rxd_release_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		standbyRise |=> rxdOut) // [RULE_09]
		else $error("wake low on receive output not withdrawn");
	normal_entry_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(!inNormal && !inSleep && normQual) |=> inNormal) // [RULE_10]
		else $error("normal not entered");
	powerup_pins_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$past(inPowerup) && inPowerup |-> !rxdOe && txdWeakPullDown && !busOe) // [RULE_11]
		else $error("power-up pin state wrong");
	dom_timeout_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		txdBlocked_q |=> !busOe) // [RULE_14]
		else $error("bus held dominant past timeout");
	dom_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		domHeld_s |-> domCnt_q != '0) // [RULE_19]
		else $error("dominant counter not running");
endmodule : lin_phy_mode_control

// *** tb/lin_bus_master_model.sv ***
// bus with pull-up and a master node that can hold it dominant
`timescale 1ns/1ns
module lin_bus_master_model (
	input wire logic sys_clk,
	input wire logic busOe,
	input wire logic busOut,
	output logic busIn
);
	logic masterDom;
	initial masterDom = 1'b0;
	// wired-and bus: pull-up gives recessive once both ends release
	assign busIn = ~((busOe & ~busOut) | masterDom);
	// caller changes the level just after a clock edge
	task automatic drive(input logic dom);
		masterDom = dom;
	endtask : drive
endmodule : lin_bus_master_model

// *** tb/lin_phy_mode_control_test.sv ***
// self-checking bench for the lin phy mode control
`timescale 1ns/1ns
`define CHECK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
	$display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module lin_phy_mode_control_test;
	typedef struct packed {
		logic txd, dom, ca, cb, oe, rxd, caOn, cbOn;
	} row_t;
	logic sys_clk, sys_rst, sleep_request_n, txdIn, busIn, csA, csB;
	logic busOut, busOe, rxdOut, rxdOe, supply_inhibit_out, supplyInhibitOe;
	logic txdStrongPullDown, txdWeakPullDown, wakeSourceRemote, wakeSourceLocal, csAOn, csBOn;
	logic [3:0] modeState;
	int num_errors = 0;
	int n_tests = 0;
	row_t rows [4] = '{8'b1000_0100, 8'b0010_1010, 8'b1111_0011, 8'b0101_1001};
	lin_phy_mode_control #(.TXD_TIMEOUT_CYCLES(50)) u_dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .sleep_request_n(sleep_request_n),
		.txdIn(txdIn), .busIn(busIn), .address_current_source_a(csA),
		.address_current_source_b(csB), .busOut(busOut), .busOe(busOe), .rxdOut(rxdOut),
		.rxdOe(rxdOe), .supply_inhibit_out(supply_inhibit_out),
		.supplyInhibitOe(supplyInhibitOe), .txdStrongPullDown(txdStrongPullDown),
		.txdWeakPullDown(txdWeakPullDown), .wakeSourceRemote(wakeSourceRemote),
		.wakeSourceLocal(wakeSourceLocal), .csAOn(csAOn), .csBOn(csBOn),
		.modeState(modeState)
	);
	lin_bus_master_model u_bus (.sys_clk(sys_clk), .busOe(busOe), .busOut(busOut),
		.busIn(busIn));
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step
	// polls once a cycle so a one-cycle standby stop is still seen
	task automatic waitMode(input logic [3:0] exp, input int lim, input string what);
		int i;
		for (i = 0; i < lim && modeState !== exp; i++) begin
			step(1);
		end
		`CHECK(what, exp, modeState)
	endtask : waitMode
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		complete_run();
	end
	initial begin
		sys_rst = 1'b1;
		sleep_request_n = 1'b0;
		txdIn = 1'b1;
		csA = 1'b0;
		csB = 1'b0;
		step(3);
		sys_rst = 1'b0;
		step(2);
		`CHECK("reset mode", lin_phy_pkg::ST_POWERUP, modeState)
		`CHECK("powerup rxd enable", 1'b0, rxdOe)
		`CHECK("powerup weak pull", 1'b1, txdWeakPullDown)
		`CHECK("powerup bus drive", 1'b0, busOe)
		`CHECK("powerup inhibit", 1'b1, supplyInhibitOe)
		// a short high must restart the qualifier, not add up
		sleep_request_n = 1'b1;
		step(200);
		sleep_request_n = 1'b0;
		step(10);
		sleep_request_n = 1'b1;
		step(240);
		`CHECK("short high", lin_phy_pkg::ST_POWERUP, modeState)
		waitMode(lin_phy_pkg::ST_NORMAL, 60, "go normal");
		foreach (rows[i]) begin
			txdIn = rows[i].txd;
			u_bus.drive(rows[i].dom);
			csA = rows[i].ca;
			csB = rows[i].cb;
			step(12);
			`CHECK("bus drive", rows[i].oe, busOe)
			`CHECK("rxd relay", rows[i].rxd, rxdOut)
			`CHECK("source a", rows[i].caOn, csAOn)
			`CHECK("source b", rows[i].cbOn, csBOn)
		end
		u_bus.drive(1'b0);
		txdIn = 1'b0;
		step(20);
		`CHECK("txd dominant", 1'b1, busOe)
		step(60);
		`CHECK("txd timeout", 1'b0, busOe)
		// host asks for sleep only while inhibit is driven, never pulled low
		`CHECK("inhibit before sleep", 1'b1, supplyInhibitOe)
		txdIn = 1'b1;
		sleep_request_n = 1'b0;
		step(200);
		sleep_request_n = 1'b1;
		step(20);
		`CHECK("short low", lin_phy_pkg::ST_NORMAL, modeState)
		sleep_request_n = 1'b0;
		step(240);
		`CHECK("low not yet", lin_phy_pkg::ST_NORMAL, modeState)
		waitMode(lin_phy_pkg::ST_SLEEP, 60, "go sleep");
		`CHECK("sleep inhibit float", 1'b0, supplyInhibitOe)
		// the model is no kinder than a real master: near-miss pulse
		u_bus.drive(1'b1);
		step(3740);
		u_bus.drive(1'b0);
		step(10);
		`CHECK("short dominant", lin_phy_pkg::ST_SLEEP, modeState)
		u_bus.drive(1'b1);
		waitMode(lin_phy_pkg::ST_STANDBY, 3800, "remote wake");
		step(2);
		u_bus.drive(1'b0);
		`CHECK("wake rxd low", 1'b0, rxdOut)
		`CHECK("wake rxd enable", 1'b1, rxdOe)
		`CHECK("remote flag", 1'b1, wakeSourceRemote)
		`CHECK("strong pull", 1'b1, txdStrongPullDown)
		`CHECK("standby inhibit", 1'b1, supplyInhibitOe)
		`CHECK("standby inhibit level", 1'b1, supply_inhibit_out)
		step(10);
		sleep_request_n = 1'b1;
		step(5);
		`CHECK("flag cleared", 1'b0, wakeSourceRemote)
		`CHECK("pull released", 1'b0, txdStrongPullDown)
		`CHECK("wake rxd withdrawn", 1'b1, rxdOut)
		`CHECK("still standby", lin_phy_pkg::ST_STANDBY, modeState)
		waitMode(lin_phy_pkg::ST_NORMAL, 300, "standby to normal");
		sleep_request_n = 1'b0;
		waitMode(lin_phy_pkg::ST_SLEEP, 300, "sleep again");
		sleep_request_n = 1'b1;
		step(100);
		sleep_request_n = 1'b0;
		step(10);
		`CHECK("short local", lin_phy_pkg::ST_SLEEP, modeState)
		sleep_request_n = 1'b1;
		waitMode(lin_phy_pkg::ST_STANDBY, 300, "local wake");
		waitMode(lin_phy_pkg::ST_NORMAL, 300, "local to normal");
		`CHECK("local flag", 1'b1, wakeSourceLocal)
		`CHECK("no remote flag", 1'b0, wakeSourceRemote)
		`CHECK("normal rxd enable", 1'b1, rxdOe)
		`CHECK("normal inhibit", 1'b1, supplyInhibitOe)
		complete_run();
	end
endmodule : lin_phy_mode_control_test
